// ---- common/tsq_pkg.sv ----
// package: register map, fields and reset values of the trigger sequencer bank
package tsq_pkg;
	localparam int unsigned TSQ_QUEUE_REGS = 16;
	localparam int unsigned TSQ_ADDR_W = 8;
	localparam logic [7:0] TSQ_OFF_CST = 8'h00;
	localparam logic [7:0] TSQ_OFF_CON = 8'h04;
	localparam logic [7:0] TSQ_OFF_BTE = 8'h08;
	localparam logic [7:0] TSQ_OFF_T0LIM = 8'h0C;
	localparam logic [7:0] TSQ_OFF_T1LIM = 8'h10;
	localparam logic [7:0] TSQ_OFF_SDLIM = 8'h14;
	localparam logic [7:0] TSQ_OFF_C0LIM = 8'h18;
	localparam logic [7:0] TSQ_OFF_C1LIM = 8'h1C;
	localparam logic [7:0] TSQ_OFF_HOLD = 8'h20;
	localparam logic [7:0] TSQ_OFF_ADJ = 8'h24;
	localparam logic [7:0] TSQ_OFF_LIT = 8'h28;
	localparam logic [7:0] TSQ_OFF_QPTR = 8'h2C;
	localparam logic [7:0] TSQ_OFF_IRQ_STAT = 8'h30;
	localparam logic [7:0] TSQ_OFF_IRQ_MASK = 8'h34;
	localparam logic [7:0] TSQ_OFF_QUE = 8'h40;
	localparam int unsigned TSQ_CST_EN = 15;
	localparam int unsigned TSQ_CST_SIDL = 13;
	localparam int unsigned TSQ_CST_TOGL = 12;
	localparam int unsigned TSQ_CST_SWT = 10;
	localparam int unsigned TSQ_CST_SSEN = 9;
	localparam int unsigned TSQ_CST_IVIS = 8;
	localparam int unsigned TSQ_CST_STRT = 7;
	localparam int unsigned TSQ_CST_WDTO = 6;
	localparam logic [15:0] TSQ_CST_MASK = 16'hB7C3;
	localparam logic [15:0] TSQ_CON_MASK = 16'hFFF7;
	localparam logic [15:0] TSQ_QPTR_MASK = 16'h001F;
	localparam int unsigned TSQ_CON_CLK_LSB = 13;
	localparam int unsigned TSQ_CON_DIV_LSB = 8;
	localparam int unsigned TSQ_CON_PWD_LSB = 4;
	localparam int unsigned TSQ_CON_WDT_LSB = 0;
	localparam int unsigned TSQ_BTE_ADC_LSB = 12;
	localparam int unsigned TSQ_BTE_IC_LSB = 8;
	localparam int unsigned TSQ_BTE_OCCS_LSB = 4;
	localparam int unsigned TSQ_BTE_OCTSS_LSB = 0;
	localparam logic [15:0] TSQ_RST16 = 16'h0000;
	localparam int unsigned TSQ_IRQ_WDTO = 0;
	localparam int unsigned TSQ_IRQ_STEP = 1;
	localparam logic [1:0] TSQ_RESP_OKAY = 2'b00;
	localparam logic [1:0] TSQ_RESP_SLVERR = 2'b10;
endpackage

// ---- src/tsq_clk_div.sv ----
// clock divider making the sequencer step enable
`timescale 1ns/1ps
module tsq_clk_div (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic [4:0] div,
	output logic tick
);
	typedef struct packed {
		logic [4:0] cnt;
		logic tick;
	} tsq_div_st_t;
	tsq_div_st_t s_r;
	tsq_div_st_t s_nxt;
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (!run) begin
			s_nxt.cnt = 5'h00; // stopped divider holds no partial count
		end else if (s_r.cnt >= div) begin
			s_nxt.cnt = 5'h00;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 5'h01;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end
	assign tick = s_r.tick;
endmodule

// ---- src/tsq_regs.sv ----
// register bank, power-mode control and sequencer core of the trigger sequencer
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module tsq_regs (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [tsq_pkg::TSQ_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [tsq_pkg::TSQ_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic idle_req,
	input wire logic sleep_req,
	input wire logic wdt_timeout_evt,
	output logic [7:0] step_cmd,
	output logic step_valid,
	output logic [15:0] bcast_enable,
	output logic irq
);
	import tsq_pkg::*;
	typedef enum logic [1:0] {SQ_OFF, SQ_RUN, SQ_FROZEN} tsq_seq_t;
	typedef struct packed {
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [15:0] cst;
		logic [15:0] con;
		logic [15:0] bte;
		logic [15:0] t0lim;
		logic [15:0] t1lim;
		logic [15:0] sdlim;
		logic [15:0] c0lim;
		logic [15:0] c1lim;
		logic [15:0] hold;
		logic [15:0] adj;
		logic [15:0] lit;
		logic [4:0] qptr;
		logic [1:0] istat;
		logic [1:0] imask;
		tsq_seq_t seq;
		logic [7:0] step_cmd;
		logic step_valid;
		logic irq;
		logic [1:0] idle_s1;
		logic [1:0] idle_s2;
	} tsq_st_t;
	tsq_st_t s_r;
	tsq_st_t s_nxt;
	// queue has no reset, so it lives outside the reset struct
	logic [15:0] queue_r [TSQ_QUEUE_REGS];
	logic que_we;
	logic [3:0] que_idx;
	logic [15:0] que_wval;
	logic enabled;
	logic suspended;
	logic seq_clk_en;
	logic tick;
	logic wr_fire;
	logic [15:0] wr16;
	logic [15:0] rd16;
	logic rd_ok;
	logic wr_ok;
	logic [7:0] ra;
	logic [15:0] qword;
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] st);
		logic [15:0] r;
		r = old;
		if (st[0]) begin
			r[7:0] = d[7:0];
		end
		if (st[1]) begin
			r[15:8] = d[15:8];
		end
		return r;
	endfunction
	assign enabled = s_r.cst[TSQ_CST_EN];
	// idle acts as sleep only when stop-in-idle is set
	assign suspended = s_r.idle_s2[1] | (s_r.idle_s2[0] & s_r.cst[TSQ_CST_SIDL]);
	assign seq_clk_en = enabled & ~suspended;
	assign qword = queue_r[s_r.qptr[4:1]];
	tsq_clk_div u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(seq_clk_en),
		.div(s_r.con[TSQ_CON_DIV_LSB +: 5]),
		.tick(tick)
	);
	always_comb begin
		ra = s_axi_araddr;
		rd_ok = 1'b1;
		rd16 = 16'h0000;
		if (ra == TSQ_OFF_CST) begin
			rd16 = s_r.cst & TSQ_CST_MASK;
		end else if (ra == TSQ_OFF_CON) begin
			rd16 = s_r.con & TSQ_CON_MASK;
		end else if (ra == TSQ_OFF_BTE) begin
			rd16 = s_r.bte;
		end else if (ra == TSQ_OFF_T0LIM) begin
			rd16 = s_r.t0lim;
		end else if (ra == TSQ_OFF_T1LIM) begin
			rd16 = s_r.t1lim;
		end else if (ra == TSQ_OFF_SDLIM) begin
			rd16 = s_r.sdlim;
		end else if (ra == TSQ_OFF_C0LIM) begin
			rd16 = s_r.c0lim;
		end else if (ra == TSQ_OFF_C1LIM) begin
			rd16 = s_r.c1lim;
		end else if (ra == TSQ_OFF_HOLD) begin
			rd16 = s_r.hold;
		end else if (ra == TSQ_OFF_ADJ) begin
			rd16 = s_r.adj;
		end else if (ra == TSQ_OFF_LIT) begin
			rd16 = s_r.lit;
		end else if (ra == TSQ_OFF_QPTR) begin
			rd16 = {11'h000, s_r.qptr};
		end else if (ra == TSQ_OFF_IRQ_STAT) begin
			rd16 = {14'h0000, s_r.istat};
		end else if (ra == TSQ_OFF_IRQ_MASK) begin
			rd16 = {14'h0000, s_r.imask};
		end else if (ra >= TSQ_OFF_QUE && ra < TSQ_OFF_QUE + 8'(4 * TSQ_QUEUE_REGS)
				&& ra[1:0] == 2'b00) begin
			rd16 = queue_r[4'((ra - TSQ_OFF_QUE) >> 2)];
		end else begin
			rd_ok = 1'b0;
		end
	end
	always_comb begin
		s_nxt = s_r;
		wr_fire = 1'b0;
		wr_ok = 1'b1;
		wr16 = 16'h0000;
		que_we = 1'b0;
		que_idx = 4'h0;
		que_wval = 16'h0000;
		s_nxt.idle_s1 = {sleep_req, idle_req};
		s_nxt.idle_s2 = s_r.idle_s1;
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = {16'h0000, rd16};
			s_nxt.rresp = rd_ok ? TSQ_RESP_OKAY : TSQ_RESP_SLVERR;
		end
		// sequencer advances only on its divided clock
		if (tick) begin
			s_nxt.step_valid = 1'b1;
			s_nxt.step_cmd = s_r.qptr[0] ? qword[15:8] : qword[7:0];
			s_nxt.qptr = s_r.qptr + 5'h01;
		end else begin
			s_nxt.step_valid = 1'b0;
		end
		// registers are decoded whether or not the module runs
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			wr_fire = 1'b1;
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			if (s_r.aw_addr == TSQ_OFF_CST) begin
				wr16 = merge16(s_r.cst, s_r.w_data, s_r.w_strb) & TSQ_CST_MASK;
				s_nxt.cst = wr16;
			end else if (s_r.aw_addr == TSQ_OFF_CON) begin
				s_nxt.con = merge16(s_r.con, s_r.w_data, s_r.w_strb) & TSQ_CON_MASK;
			end else if (s_r.aw_addr == TSQ_OFF_BTE) begin
				s_nxt.bte = merge16(s_r.bte, s_r.w_data, s_r.w_strb);
			end else if (s_r.aw_addr == TSQ_OFF_T0LIM) begin
				s_nxt.t0lim = merge16(s_r.t0lim, s_r.w_data, s_r.w_strb);
			end else if (s_r.aw_addr == TSQ_OFF_T1LIM) begin
				s_nxt.t1lim = merge16(s_r.t1lim, s_r.w_data, s_r.w_strb);
			end else if (s_r.aw_addr == TSQ_OFF_SDLIM) begin
				s_nxt.sdlim = merge16(s_r.sdlim, s_r.w_data, s_r.w_strb);
			end else if (s_r.aw_addr == TSQ_OFF_C0LIM) begin
				s_nxt.c0lim = merge16(s_r.c0lim, s_r.w_data, s_r.w_strb);
			end else if (s_r.aw_addr == TSQ_OFF_C1LIM) begin
				s_nxt.c1lim = merge16(s_r.c1lim, s_r.w_data, s_r.w_strb);
			end else if (s_r.aw_addr == TSQ_OFF_HOLD) begin
				s_nxt.hold = merge16(s_r.hold, s_r.w_data, s_r.w_strb);
			end else if (s_r.aw_addr == TSQ_OFF_ADJ) begin
				s_nxt.adj = merge16(s_r.adj, s_r.w_data, s_r.w_strb);
			end else if (s_r.aw_addr == TSQ_OFF_LIT) begin
				s_nxt.lit = merge16(s_r.lit, s_r.w_data, s_r.w_strb);
			end else if (s_r.aw_addr == TSQ_OFF_QPTR) begin
				if (s_r.w_strb[0]) begin
					s_nxt.qptr = s_r.w_data[4:0]; // write wins over a step
				end
			end else if (s_r.aw_addr == TSQ_OFF_IRQ_STAT) begin
				s_nxt.istat = s_nxt.istat & ~(s_r.w_strb[0] ? s_r.w_data[1:0] : 2'b00);
			end else if (s_r.aw_addr == TSQ_OFF_IRQ_MASK) begin
				if (s_r.w_strb[0]) begin
					s_nxt.imask = s_r.w_data[1:0];
				end
			end else if (s_r.aw_addr >= TSQ_OFF_QUE
					&& s_r.aw_addr < TSQ_OFF_QUE + 8'(4 * TSQ_QUEUE_REGS)
					&& s_r.aw_addr[1:0] == 2'b00) begin
				que_we = 1'b1;
				que_idx = 4'((s_r.aw_addr - TSQ_OFF_QUE) >> 2);
				que_wval = merge16(queue_r[que_idx], s_r.w_data, s_r.w_strb);
			end else begin
				wr_ok = 1'b0;
			end
			s_nxt.bresp = wr_ok ? TSQ_RESP_OKAY : TSQ_RESP_SLVERR;
		end
		// hardware events set after software clears: set wins
		if (wdt_timeout_evt && enabled) begin
			s_nxt.cst[TSQ_CST_WDTO] = 1'b1;
			s_nxt.istat[TSQ_IRQ_WDTO] = 1'b1;
		end
		if (tick) begin
			s_nxt.istat[TSQ_IRQ_STEP] = 1'b1;
		end
		case (s_r.seq)
			SQ_OFF: begin
				if (enabled) begin
					s_nxt.seq = SQ_RUN;
				end
			end
			SQ_RUN: begin
				if (suspended) begin
					s_nxt.seq = SQ_FROZEN;
				end
			end
			SQ_FROZEN: begin
				if (!suspended) begin
					s_nxt.seq = SQ_RUN;
				end
			end
			default: begin
				s_nxt.seq = SQ_OFF;
			end
		endcase
		// disabling returns the sequencer to reset, pointer and queue untouched
		if (!s_nxt.cst[TSQ_CST_EN]) begin
			s_nxt.seq = SQ_OFF;
			s_nxt.step_valid = 1'b0;
			s_nxt.step_cmd = 8'h00;
			s_nxt.cst[TSQ_CST_STRT] = 1'b0;
		end
		s_nxt.irq = |(s_nxt.istat & s_nxt.imask);
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.seq <= SQ_OFF;
		end else begin
			s_r <= s_nxt;
		end
	end
	// no reset on the queue: contents undefined until written
	always_ff @(posedge aclk) begin
		if (que_we) begin
			queue_r[que_idx] <= que_wval;
		end
	end
	// ready is the inverse of the holding flag: one transfer per channel in flight
	assign s_axi_awready = ~s_r.aw_got;
	assign s_axi_wready = ~s_r.w_got;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_arready = ~s_r.rvalid;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign step_cmd = s_r.step_cmd;
	assign step_valid = s_r.step_valid;
	assign bcast_enable = s_r.bte;
	assign irq = s_r.irq;
	a_reset_zero: assert property (@(posedge aclk)
			!aresetn |=> s_r.cst == 16'h0000 && s_r.con == 16'h0000 && s_r.qptr == 5'h00)
		else $error("registers not zero after reset");
	a_off_no_step: assert property (@(posedge aclk) disable iff (!aresetn)
			!enabled |-> !step_valid)
		else $error("step issued while disabled");
	// one stray tick may still follow the drop of enable, so it is excluded
	a_off_ptr_hold: assert property (@(posedge aclk) disable iff (!aresetn)
			!enabled && !tick && !wr_fire |=> $stable(s_r.qptr))
		else $error("pointer moved while disabled");
	a_disable_seq: assert property (@(posedge aclk) disable iff (!aresetn)
			$fell(enabled) |-> s_r.seq == SQ_OFF)
		else $error("sequencer not reset on disable");
	a_freeze_ptr: assert property (@(posedge aclk) disable iff (!aresetn)
			suspended && $past(suspended) && !wr_fire |=> $stable(s_r.qptr))
		else $error("pointer moved while frozen");
	a_idle_stop: assert property (@(posedge aclk) disable iff (!aresetn)
			s_r.idle_s2[0] && s_r.cst[TSQ_CST_SIDL] && !s_r.idle_s2[1] |-> suspended)
		else $error("idle with stop-in-idle not suspended");
	a_idle_run: assert property (@(posedge aclk) disable iff (!aresetn)
			s_r.idle_s2 == 2'b01 && !s_r.cst[TSQ_CST_SIDL] && enabled |-> seq_clk_en)
		else $error("idle without stop-in-idle halted module");
	a_step_stat: assert property (@(posedge aclk) disable iff (!aresetn)
			tick |=> s_r.istat[TSQ_IRQ_STEP])
		else $error("step status not set");
	a_ptr_upper: assert property (@(posedge aclk) disable iff (!aresetn)
			s_axi_arvalid && s_axi_arready && s_axi_araddr == TSQ_OFF_QPTR
			|=> s_axi_rdata[31:5] == 27'h0)
		else $error("pointer upper bits not zero");
	a_rd_unmapped: assert property (@(posedge aclk) disable iff (!aresetn)
			s_axi_arvalid && s_axi_arready && !rd_ok
			|=> s_axi_rresp == TSQ_RESP_SLVERR && s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");
	a_step_byte: assert property (@(posedge aclk) disable iff (!aresetn)
			tick && !que_we |=> step_cmd == (!enabled ? 8'h00 : ($past(s_r.qptr[0])
			? $past(qword[15:8]) : $past(qword[7:0]))))
		else $error("wrong queue byte issued");
	a_write_off: assert property (@(posedge aclk) disable iff (!aresetn)
			wr_fire && s_r.aw_addr == TSQ_OFF_BTE && s_r.w_strb == 4'hF
			|=> bcast_enable == $past(s_r.w_data[15:0]))
		else $error("broadcast write lost");
	a_wdt_set: assert property (@(posedge aclk) disable iff (!aresetn)
			wdt_timeout_evt && enabled |=> s_r.cst[TSQ_CST_WDTO] && s_r.istat[TSQ_IRQ_WDTO])
		else $error("watchdog flag not set");
	c_run: cover property (@(posedge aclk) disable iff (!aresetn) step_valid);
	c_freeze: cover property (@(posedge aclk) disable iff (!aresetn) s_r.seq == SQ_FROZEN);
	c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
	c_wrap: cover property (@(posedge aclk) disable iff (!aresetn) s_r.qptr == 5'h1F && tick);
	c_idle_run: cover property (@(posedge aclk) disable iff (!aresetn)
			s_r.idle_s2 == 2'b01 && seq_clk_en);
endmodule

// ---- verif/tsq_trig_sink.sv ----
// partner model: peripheral side that logs every issued step command
`timescale 1ns/1ps
module tsq_trig_sink (
	input wire logic aclk,
	input wire logic [7:0] step_cmd,
	input wire logic step_valid
);
	int cnt = 0;
	logic [7:0] cmds [0:63];
	// a trigger is acted on only in the cycle its strobe is high
	always @(posedge aclk) begin
		if (step_valid === 1'h1) begin
			cmds[cnt[5:0]] <= step_cmd;
			cnt <= cnt + 1;
		end
	end
endmodule

// ---- verif/test_trigger_sequencer_power_regs.sv ----
// self-checking bench for the trigger sequencer register bank
`timescale 1ns/1ps
module test_trigger_sequencer_power_regs;
	import tsq_pkg::*;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, idle_req = 0, sleep_req = 0, wdt_evt = 0;
	logic [7:0] awaddr = 0, araddr = 0, step_cmd;
	logic [31:0] wdata = 0, rdata;
	logic awready, wready, bvalid, arready, rvalid, step_valid, irq;
	logic [1:0] bresp, rresp, rs;
	logic [15:0] bcast;
	int err_total = 0, comparisons = 0, cyc = 0;

	tsq_regs dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .idle_req(idle_req),
		.sleep_req(sleep_req), .wdt_timeout_evt(wdt_evt), .step_cmd(step_cmd),
		.step_valid(step_valid), .bcast_enable(bcast), .irq(irq)
	);
	tsq_trig_sink sink (.aclk(aclk), .step_cmd(step_cmd), .step_valid(step_valid));

	initial begin
		forever #10 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1 && n < 100);
		if (bvalid !== 1'h1) err_total++;
		r = bresp;
		bready <= 1'h0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1 && n < 100);
		if (rvalid !== 1'h1) err_total++;
		d = rdata;
		r = rresp;
		rready <= 1'h0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, exp);
	endtask

	// irq is registered from status and mask, so let two edges pass
	task automatic irq_chk(input logic exp);
		repeat (2) @(posedge aclk);
		chk({31'h0, irq}, {31'h0, exp});
	endtask

	task automatic wait_cnt(input int target);
		int n = 0;
		while (sink.cnt < target && n < 500) begin
			@(posedge aclk);
			n++;
		end
		if (sink.cnt < target) err_total++;
	endtask

	task automatic sc_reset_vals();
		logic [31:0] d;
		for (int a = 0; a <= 8'h34; a += 4) rchk(8'(a), 32'h0);
		rd(8'h38, d, rs);
		chk({30'h0, rs}, {30'h0, TSQ_RESP_SLVERR});
		chk(d, 32'h0);
		wr(8'h3C, 16'hFFFF, rs);
		chk({30'h0, rs}, {30'h0, TSQ_RESP_SLVERR});
		chk({16'h0, bcast}, 32'h0);
		irq_chk(1'h0);
	endtask

	task automatic sc_layout();
		for (int a = 8'h0C; a <= 8'h28; a += 4) wr(8'(a), 16'h5A00 | 16'(a), rs);
		for (int a = 8'h0C; a <= 8'h28; a += 4) rchk(8'(a), 32'h5A00 | a);
		wr(TSQ_OFF_CON, 16'hFFFF, rs);
		rchk(TSQ_OFF_CON, 32'hFFF7);
		wr(TSQ_OFF_QPTR, 16'hFFFF, rs);
		rchk(TSQ_OFF_QPTR, 32'h001F);
		wr(TSQ_OFF_BTE, 16'hA5C3, rs);
		rchk(TSQ_OFF_BTE, 32'hA5C3);
		chk({16'h0, bcast}, 32'hA5C3);
		wr(TSQ_OFF_CST, 16'h3343, rs);
		rchk(TSQ_OFF_CST, 32'h3343);
		wr(TSQ_OFF_CST, 16'h483C, rs);
		rchk(TSQ_OFF_CST, 32'h0);
		wr(TSQ_OFF_CON, 16'h0000, rs);
	endtask

	task automatic sc_run();
		int base, c;
		for (int n = 0; n < TSQ_QUEUE_REGS; n++)
			wr(8'(TSQ_OFF_QUE + 4 * n), {8'(2 * n + 1), 8'(2 * n)}, rs);
		wr(TSQ_OFF_QPTR, 16'h0000, rs);
		base = sink.cnt;
		wr(TSQ_OFF_CST, 16'hA000, rs);
		wait_cnt(base + 3);
		idle_req <= 1'h1;
		repeat (6) @(posedge aclk);
		c = sink.cnt;
		repeat (20) @(posedge aclk);
		chk(sink.cnt, c);
		idle_req <= 1'h0;
		wait_cnt(c + 3);
		// sleep while enabled, on purpose, to see the freeze
		sleep_req <= 1'h1;
		repeat (6) @(posedge aclk);
		c = sink.cnt;
		repeat (20) @(posedge aclk);
		chk(sink.cnt, c);
		sleep_req <= 1'h0;
		wait_cnt(base + 40);
		for (int i = 0; i < 40; i++)
			chk(32'(sink.cmds[(base + i) % 64]), i % 32);
		wr(TSQ_OFF_CST, 16'h8000, rs);
		idle_req <= 1'h1;
		c = sink.cnt;
		repeat (20) @(posedge aclk);
		chk(32'(sink.cnt > c + 10), 32'h1);
		idle_req <= 1'h0;
		// orderly shutdown before anything else
		wr(TSQ_OFF_CST, 16'h0000, rs);
		repeat (2) @(posedge aclk);
		c = sink.cnt;
		repeat (20) @(posedge aclk);
		chk(sink.cnt, c);
		chk({24'h0, step_cmd}, 32'h0);
	endtask

	task automatic sc_irq();
		rchk(TSQ_OFF_IRQ_STAT, 32'h2);
		wr(TSQ_OFF_IRQ_MASK, 16'h0002, rs);
		irq_chk(1'h1);
		wr(TSQ_OFF_IRQ_MASK, 16'h0000, rs);
		irq_chk(1'h0);
		wr(TSQ_OFF_IRQ_MASK, 16'h0003, rs);
		wr(TSQ_OFF_IRQ_STAT, 16'h0002, rs);
		irq_chk(1'h0);
		// watchdog events count only while enabled; sleep keeps steps off the status
		sleep_req <= 1'h1;
		wr(TSQ_OFF_CST, 16'h8000, rs);
		wdt_evt <= 1'h1;
		@(posedge aclk);
		wdt_evt <= 1'h0;
		irq_chk(1'h1);
		rchk(TSQ_OFF_CST, 32'h8040);
		rchk(TSQ_OFF_IRQ_STAT, 32'h1);
		wr(TSQ_OFF_T0LIM, 16'h1234, rs);
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		sleep_req <= 1'h0;
		rchk(TSQ_OFF_T0LIM, 32'h0);
		rchk(TSQ_OFF_CST, 32'h0);
		irq_chk(1'h0);
	endtask

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		sc_reset_vals();
		sc_layout();
		sc_run();
		sc_irq();
		stop_test();
	end

	// the whole run needs a few hundred cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			stop_test();
		end
	end
endmodule
